/* rtl/lfs_pkg.sv */
// Purpose: Shared constants and carrier types for the LED string fault supervisor.
// Assumes: One 40 MHz clock; APB register access with 32-bit data.
// Notes: Register byte offsets are word aligned.
package lfs_pkg;
  localparam int unsigned NCH = 8;
  localparam logic [2:0] TMO_TICKS = 3'h6;
  localparam logic [1:0] MAX_DOWN = 2'h3;
  localparam logic [7:0] DEV_ADDR = 8'h58;
  // Register byte addresses.
  localparam logic [7:0] OFS_BRIGHT = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_FAULT = 8'h08;
  localparam logic [7:0] OFS_CFG = 8'h3c;
  localparam logic [7:0] OFS_CHAN = 8'h40;
  localparam logic [7:0] OFS_GOOD = 8'h44;
  // Reset values.
  localparam logic [7:0] RST_BRIGHT = 8'hff;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_CFG = 8'h01;
  // Configuration fields: threshold select and short-detect disable; control register backlight bit.
  localparam int unsigned CFG_THR_LSB = 0;
  localparam int unsigned CFG_SDIS_BIT = 2;
  localparam int unsigned CTRL_BL_BIT = 0;
  // Fault status bit positions.
  localparam int unsigned FLT_ANY_BIT = 0;
  localparam int unsigned FLT_THRM_BIT = 1;
  localparam int unsigned FLT_OV_BIT = 2;

  typedef struct packed {
    logic [NCH-1:0] at_target;
    logic [NCH-1:0] conducting;
    logic [NCH-1:0][2:0] above_lvl;
    logic ov;
    logic otp_lo;
    logic otp_hi;
  } lfs_sense_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } lfs_apb_rsp_s;
endpackage : lfs_pkg

/* rtl/lfs_chan_timer.sv */
// Purpose: Per-channel fault time-out counter on dimming ticks.
// Assumes: tick is a one-cycle enable on the same clock.
// Notes: Expiry is a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
module lfs_chan_timer
  import lfs_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Control.
  input wire logic fault,
  input wire logic tick,
  // Result.
  output logic expire
);
  typedef struct packed {
    logic [2:0] cnt;
    logic exp;
  } lfs_tmr_s;
  lfs_tmr_s s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.exp = 1'b0;
    if (!fault) begin
      s_d.cnt = 3'h0;
    end else if (tick) begin
      if (s_q.cnt == TMO_TICKS - 3'h1) begin
        s_d.cnt = 3'h0;
        s_d.exp = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 3'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign expire = s_q.exp;
endmodule : lfs_chan_timer
`default_nettype wire

/* rtl/lfs_supervisor.sv */
// Purpose: Fault supervisor for eight LED strings with an APB register file.
// Assumes: Sense inputs are asynchronous comparator levels; dim_tick is an asynchronous pin.
// Notes: Registers written over APB stand in for the serial host's write byte path.
//
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Short above threshold disables channel after six ticks.
// - Short expiry with three down kills all.
// - Open channel under overvoltage off after six ticks.
// - Zener-bridged conducting channel stays on, sets regulation.
// - Upper over-temperature switches all channels off.
// - Lower over-temperature times out under-target channels.
// - Overvoltage times out under-target channels only.
// - Completed write stores data in selected register; here only with pstrb[0] set, and fault, channel and good ignore writes.
// - Device drives data only in own cycles.
// - Direction bit high reads, low writes; here APB pwrite high writes and low reads.
// - Good once at target; later drop means open.
// - Upper over-temperature latches off, sets thermal bit.
// - Short threshold selectable, default middle, disableable.
module lfs_supervisor
  import lfs_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Analog comparator levels and dimming tick.
  input wire lfs_sense_s sense,
  input wire logic dim_tick,
  // Channel drive.
  output logic [NCH-1:0] chan_en,
  output logic [NCH-1:0] reg_select,
  output logic boost_en,
  output logic [7:0] brightness
);
  typedef struct packed {
    lfs_sense_s s1;
    lfs_sense_s s2;
    logic [2:0] tk;
    logic [7:0] bright;
    logic [7:0] ctrl;
    logic [7:0] cfg;
    logic [7:0] fault;
    logic [NCH-1:0] good;
    logic [NCH-1:0] down;
    logic [NCH-1:0] regsel;
    logic all_off;
    logic thrm_off;
    logic bl_prev;
    logic [NCH-1:0] chan_on;
    logic boost;
    lfs_apb_rsp_s rsp;
  } lfs_state_s;
  lfs_state_s q, d;

  logic [NCH-1:0] short_f, open_f, expire;
  logic tick_pulse;
  logic run;

  function automatic logic [2:0] count_ones(input logic [NCH-1:0] v);
    logic [2:0] n;
    n = 3'h0;
    for (int i = 0; i < NCH; i++) begin
      if (v[i] && n != 3'h7) begin
        n = n + 3'h1;
      end
    end
    return n;
  endfunction : count_ones

  function automatic logic [31:0] read_mux(input logic [7:0] a, input lfs_state_s s);
    logic [31:0] r;
    r = 32'h0;
    unique case (a)
      OFS_BRIGHT: r[7:0] = s.bright;
      OFS_CTRL: r[7:0] = s.ctrl;
      OFS_FAULT: r[7:0] = s.fault;
      OFS_CFG: r[7:0] = s.cfg;
      OFS_CHAN: r[NCH-1:0] = ~s.down & {NCH{~s.all_off}};
      OFS_GOOD: r[NCH-1:0] = s.good;
      default: r = 32'h0;
    endcase
    return r;
  endfunction : read_mux

  function automatic logic addr_ok(input logic [7:0] a);
    return a == OFS_BRIGHT || a == OFS_CTRL || a == OFS_FAULT || a == OFS_CFG
           || a == OFS_CHAN || a == OFS_GOOD;
  endfunction : addr_ok

  assign tick_pulse = q.tk[1] & ~q.tk[2];
  // Faults are judged only while strings are driven, since an unlit string reads as open.
  assign run = q.bl_prev & ~q.all_off & ~q.thrm_off;

  // Fault conditions per channel; expiry handled by one timer each.
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    logic thr_hit;
    always_comb begin
      thr_hit = q.s2.above_lvl[g][q.cfg[CFG_THR_LSB +: 2] > 2'h2 ? 2'h1 : q.cfg[CFG_THR_LSB +: 2]];
    end
    // Short detection only below the upper thermal limit.
    assign short_f[g] = thr_hit & ~q.cfg[CFG_SDIS_BIT] & ~q.s2.otp_hi & ~q.down[g] & run;
    // Open: not good under overvoltage or lower thermal, or dropped after good.
    assign open_f[g] = ~q.down[g] & ~q.s2.at_target[g]
                       & (q.good[g] | q.s2.ov | q.s2.otp_lo) & ~thr_hit & run;
    lfs_chan_timer u_tmr (
      .pclk(pclk),
      .presetn(presetn),
      .fault(short_f[g] | open_f[g]),
      .tick(tick_pulse),
      .expire(expire[g])
    );
  end

  always_comb begin
    logic wr_acc;
    logic [7:0] hi_v;
    wr_acc = 1'b0;
    hi_v = 8'h0;
    d = q;
    d.s1 = sense;
    d.s2 = q.s1;
    d.tk = {q.tk[1:0], dim_tick};
    d.rsp.pready = 1'b0;
    d.rsp.pslverr = 1'b0;
    d.rsp.prdata = 32'h0;
    d.bl_prev = q.ctrl[CTRL_BL_BIT];
    // Good marking.
    d.good = q.good | (q.s2.at_target & ~q.down);
    // Time-outs disable single channels.
    d.down = q.down | expire;
    if (|(expire & short_f) && count_ones(q.down) >= {1'b0, MAX_DOWN}) begin
      d.all_off = 1'b1;
    end
    if (q.s2.otp_hi) begin
      d.thrm_off = 1'b1;
      d.fault[FLT_THRM_BIT] = 1'b1;
    end
    if (q.s2.ov) begin
      d.fault[FLT_OV_BIT] = 1'b1;
    end
    if (|expire) begin
      d.fault[FLT_ANY_BIT] = 1'b1;
    end
    // APB: answer one cycle after the access phase starts.
    if (psel && penable && !q.rsp.pready) begin
      d.rsp.pready = 1'b1;
      d.rsp.pslverr = ~addr_ok(paddr);
      d.rsp.prdata = pwrite ? 32'h0 : read_mux(paddr, q);
      wr_acc = pwrite & addr_ok(paddr) & pstrb[0];
    end
    if (wr_acc) begin
      hi_v = pwdata[7:0];
      unique case (paddr)
        OFS_BRIGHT: d.bright = hi_v;
        OFS_CTRL: d.ctrl = hi_v & 8'h07;
        OFS_CFG: d.cfg = hi_v & 8'h07;
        default: d.fault = d.fault;
      endcase
    end
    // Re-enabling the backlight clears the latched shutdown; hardware set still wins.
    if (q.ctrl[CTRL_BL_BIT] && !q.bl_prev) begin
      d.thrm_off = q.s2.otp_hi;
      d.all_off = 1'b0;
      d.down = expire;
      d.good = q.s2.at_target & ~expire;
      d.fault = 8'h00;
      d.fault[FLT_THRM_BIT] = q.s2.otp_hi;
      d.fault[FLT_OV_BIT] = q.s2.ov;
      d.fault[FLT_ANY_BIT] = |expire;
    end
    // Enables come from flops so the pins never glitch while the state decodes.
    d.chan_on = ~d.down & {NCH{~d.all_off & ~d.thrm_off & d.bl_prev}};
    d.boost = ~d.thrm_off & ~d.all_off & d.bl_prev;
    // Regulation follows conducting strings still on, including zener-bridged ones.
    d.regsel = q.s2.conducting & d.chan_on;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.bright <= RST_BRIGHT;
      q.ctrl <= RST_CTRL;
      q.cfg <= RST_CFG;
    end else begin
      q <= d;
    end
  end

  assign prdata = q.rsp.prdata;
  assign pready = q.rsp.pready;
  assign pslverr = q.rsp.pslverr;
  assign chan_en = q.chan_on;
  assign reg_select = q.regsel;
  assign boost_en = q.boost;
  assign brightness = q.bright;
endmodule : lfs_supervisor
`default_nettype wire

/* verif/lfs_supervisor_properties.sv */
// Purpose: Port checks for the supervisor.
// Assumes: One clock, reset active low.
// Notes: Bound to every supervisor.
`timescale 1ns/1ps
`default_nettype none
module lfs_supervisor_properties
  import lfs_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Bus.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Strings.
  input wire lfs_sense_s sense,
  input wire logic dim_tick,
  input wire logic [NCH-1:0] chan_en,
  input wire logic [NCH-1:0] reg_select,
  input wire logic boost_en,
  input wire logic [7:0] brightness
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_wait; psel && penable && !pready |=> pready; endproperty
  a_wait: assert property (p_wait)
    else $error("no answer after one wait");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse)
    else $error("ready too long");
  property p_quiet; !pready |-> prdata == 32'h0; endproperty
  a_quiet: assert property (p_quiet)
    else $error("read data outside answer");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err)
    else $error("error without ready");
  property p_up; pready |-> prdata[31:8] == 24'h0; endproperty
  a_up: assert property (p_up)
    else $error("upper read bits set");
  property p_wr;
    pready && pwrite && pstrb[0] && paddr == OFS_BRIGHT |=> brightness == $past(pwdata[7:0]);
  endproperty
  a_wr: assert property (p_wr)
    else $error("write not stored");
  property p_rd; pready && !pwrite && paddr == OFS_BRIGHT |-> prdata[7:0] == brightness; endproperty
  a_rd: assert property (p_rd)
    else $error("read data wrong");
  property p_hot; sense.otp_hi [*4] |=> chan_en == 8'h00 && !boost_en; endproperty
  a_hot: assert property (p_hot)
    else $error("strings on while hot");
  property p_reg; 1'b1 |-> (reg_select & ~chan_en & ~$past(chan_en)) == 8'h00; endproperty
  a_reg: assert property (p_reg)
    else $error("off string regulates");
endmodule : lfs_supervisor_properties
bind lfs_supervisor lfs_supervisor_properties i_props (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .sense, .dim_tick, .chan_en, .reg_select,
  .boost_en, .brightness);
`default_nettype wire

/* verif/lfs_strings.sv */
// Purpose: Model of the LED strings and tick pin.
// Assumes: Bench sets short, open and flag masks.
// Notes: Behavioural, no analog detail.
`timescale 1ns/1ps
`default_nettype none
module lfs_strings
  import lfs_pkg::*;
(
  // Clock.
  input wire logic pclk,
  // Fault masks and ov, otp_lo, otp_hi.
  input wire logic [NCH-1:0] short_m,
  input wire logic [NCH-1:0] open_m,
  input wire logic [2:0] flags,
  // Device side.
  input wire logic [NCH-1:0] chan_en,
  output var lfs_sense_s sense,
  output wire logic dim_tick
);
  logic [2:0] div_q = 3'h0;
  // Ticks run free, one every eight clocks, so a time-out takes about 48 clocks.
  always @(posedge pclk) div_q <= div_q + 3'h1;
  assign dim_tick = div_q[2];
  always_comb begin
    // A shorted string sits between the middle and the upper threshold.
    for (int i = 0; i < NCH; i++) sense.above_lvl[i] = short_m[i] ? 3'h3 : 3'h0;
    sense.at_target = chan_en & ~open_m;
    sense.conducting = chan_en & ~open_m;
    {sense.ov, sense.otp_lo, sense.otp_hi} = flags;
  end
endmodule : lfs_strings
`default_nettype wire

/* verif/testbench.sv */
// Purpose: Self-checking bench for the supervisor.
// Assumes: APB master tasks, string model.
// Notes: Waits are in eight-clock ticks.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import lfs_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [3:0] pstrb = 4'h1;
  logic [7:0] brightness;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, boost_en, dim_tick;
  logic [NCH-1:0] chan_en, reg_select, sh = 8'h00, op = 8'h00;
  logic [2:0] fl = 3'h0;
  lfs_sense_s sense;
  int fails = 0, tests_run = 0;
  always #12.5 pclk = ~pclk;
  lfs_strings i_lfs_strings (.pclk, .short_m(sh), .open_m(op), .flags(fl), .chan_en, .sense, .dim_tick);
  lfs_supervisor i_lfs_supervisor (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .sense, .dim_tick, .chan_en, .reg_select, .boost_en,
    .brightness);
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    tests_run++;
    if (got !== ex) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  task automatic ticks(input int k);
    repeat (k * 8) @(posedge pclk);
  endtask : ticks
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    #500000;
    fails++;
    tally_and_finish();
  end
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFS_BRIGHT, 8'h00);
    chk("bright", 32'hff, rd);
    apb(1'b0, OFS_CFG, 8'h00);
    chk("cfg", 32'h01, rd);
    apb(1'b0, 8'h10, 8'h00);
    chk("slverr", 32'h1, 32'(er));
    apb(1'b1, OFS_BRIGHT, 8'h5a);
    apb(1'b0, OFS_BRIGHT, 8'h00);
    chk("bright wr", 32'h5a, rd);
    pstrb <= 4'h0;
    apb(1'b1, OFS_BRIGHT, 8'h33);
    pstrb <= 4'h1;
    apb(1'b0, OFS_BRIGHT, 8'h00);
    chk("strobe off", 32'h5a, rd);
    $display("end of register test");
    apb(1'b1, OFS_CTRL, 8'h01);
    sh <= 8'h07;
    ticks(4);
    sh <= 8'h00;
    ticks(1);
    sh <= 8'h07;
    ticks(4);
    chk("early", 32'hff, 32'(chan_en));
    ticks(6);
    chk("short", 32'hf8, 32'(chan_en));
    apb(1'b0, OFS_FAULT, 8'h00);
    chk("fault", 32'h1, 32'(rd[FLT_ANY_BIT]));
    sh <= 8'h0f;
    ticks(10);
    chk("all off", 32'h00, 32'(chan_en));
    $display("end of short test");
    apb(1'b1, OFS_CTRL, 8'h00);
    sh <= 8'h00;
    apb(1'b1, OFS_CTRL, 8'h01);
    op <= 8'h10;
    fl <= 3'h4;
    ticks(10);
    chk("open ov", 32'hef, 32'(chan_en));
    chk("reg open", 32'hef, 32'(reg_select));
    op <= 8'h30;
    fl <= 3'h2;
    ticks(10);
    chk("otp lo", 32'hcf, 32'(chan_en));
    fl <= 3'h1;
    ticks(1);
    chk("otp hi", 32'h00, 32'(chan_en));
    chk("boost hot", 32'h0, 32'(boost_en));
    fl <= 3'h0;
    ticks(2);
    apb(1'b0, OFS_FAULT, 8'h00);
    chk("thermal", 32'h1, 32'(rd[FLT_THRM_BIT]));
    chk("latched", 32'h00, 32'(chan_en));
    $display("end of open and heat test");
    apb(1'b1, OFS_CFG, 8'h02);
    apb(1'b1, OFS_CTRL, 8'h00);
    op <= 8'h00;
    sh <= 8'h01;
    apb(1'b1, OFS_CTRL, 8'h01);
    ticks(10);
    chk("high thr", 32'hff, 32'(chan_en));
    chk("boost on", 32'h1, 32'(boost_en));
    chk("regulation", 32'hff, 32'(reg_select));
    apb(1'b1, OFS_CFG, 8'h05);
    ticks(10);
    chk("no short", 32'hff, 32'(chan_en));
    apb(1'b1, OFS_CFG, 8'h01);
    ticks(10);
    chk("short back", 32'hfe, 32'(chan_en));
    $display("end of detect disable test");
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
